// ---- hw/epc_pkg.sv ----
// Constants of the shape parameter and foreground colour register bank
package epc_pkg;

  localparam int          COORD_W          = 13;
  localparam int          IDX_W            = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_SHAPE_CTRL   = 8'h76;
  localparam logic [7:0]  IDX_MAJOR_LO     = 8'h77;
  localparam logic [7:0]  IDX_MAJOR_HI     = 8'h78;
  localparam logic [7:0]  IDX_MINOR_LO     = 8'h79;
  localparam logic [7:0]  IDX_MINOR_HI     = 8'h7a;
  localparam logic [7:0]  IDX_CENTRE_X_LO  = 8'h7b;
  localparam logic [7:0]  IDX_CENTRE_X_HI  = 8'h7c;
  localparam logic [7:0]  IDX_CENTRE_Y_LO  = 8'h7d;
  localparam logic [7:0]  IDX_CENTRE_Y_HI  = 8'h7e;
  localparam logic [7:0]  IDX_COLOUR_MODE  = 8'h10;
  localparam logic [7:0]  IDX_FG_RED       = 8'hd2;
  localparam logic [7:0]  IDX_FG_GREEN     = 8'hd3;
  localparam logic [7:0]  IDX_FG_BLUE      = 8'hd4;

  // Shape control field positions
  localparam int          SC_RUN_BIT       = 7;
  localparam int          SC_FILL_BIT      = 6;
  localparam int          SC_SHAPE_LSB     = 4;
  localparam int          SC_PART_LSB      = 0;

  // Reset values
  localparam logic [12:0] COORD_RST        = 13'h0000;
  localparam logic [7:0]  FG_RST           = 8'hff;
  localparam logic [1:0]  FIELD2_RST       = 2'h0;

  typedef enum logic [1:0]
  {
    EPC_SHAPE_ELLIPSE = 2'b00,
    EPC_SHAPE_ARC     = 2'b01,
    EPC_SHAPE_RECT    = 2'b10,
    EPC_SHAPE_RRECT   = 2'b11
  } epc_shape_e;

  typedef enum logic [1:0]
  {
    EPC_MODE_256  = 2'b00,
    EPC_MODE_65K  = 2'b01,
    EPC_MODE_16M  = 2'b10,
    EPC_MODE_16MB = 2'b11
  } epc_mode_e;

  localparam logic [1:0]  MODE_RST         = 2'b00;

endpackage

// ---- hw/epc_coord_reg.sv ----
// One 13-bit coordinate held as a low byte and a five-bit high byte
`timescale 1ns/1ps
`default_nettype none
module epc_coord_reg
(
  // Clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // Byte writes
  input  wire logic                           wr_lo_i,
  input  wire logic                           wr_hi_i,
  input  wire logic [7:0]                     wdata_i,
  // Held value in pixels
  output logic      [epc_pkg::COORD_W-1:0]    value_o
);

  logic [7:0] lo_r;
  logic [4:0] hi_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lo_r <= epc_pkg::COORD_RST[7:0];
    end
    else if (wr_lo_i)
    begin
      lo_r <= wdata_i;
    end
  end

  // Upper three bits of the high byte are dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_r <= epc_pkg::COORD_RST[12:8];
    end
    else if (wr_hi_i)
    begin
      hi_r <= wdata_i[4:0];
    end
  end

  assign value_o = {hi_r, lo_r};

endmodule
`default_nettype wire

// ---- hw/epc_fg_fmt.sv ----
// Picks the used foreground colour bits for the current colour depth
`timescale 1ns/1ps
`default_nettype none
module epc_fg_fmt
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Colour depth and raw bytes
  input  wire logic [1:0]  mode_i,
  input  wire logic [7:0]  red_i,
  input  wire logic [7:0]  green_i,
  input  wire logic [7:0]  blue_i,
  // Right-justified components
  output logic      [7:0]  red_o,
  output logic      [7:0]  green_o,
  output logic      [7:0]  blue_o
);

  logic [7:0] red_nxt;
  logic [7:0] green_nxt;
  logic [7:0] blue_nxt;

  always_comb
  begin
    case (mode_i)
      epc_pkg::EPC_MODE_256:
      begin
        red_nxt   = {5'h00, red_i[7:5]};
        green_nxt = {5'h00, green_i[7:5]};
        blue_nxt  = {6'h00, blue_i[7:6]};
      end
      epc_pkg::EPC_MODE_65K:
      begin
        red_nxt   = {3'h0, red_i[7:3]};
        green_nxt = {2'h0, green_i[7:2]};
        blue_nxt  = {3'h0, blue_i[7:3]};
      end
      default:
      begin
        red_nxt   = red_i;
        green_nxt = green_i;
        blue_nxt  = blue_i;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      red_o   <= epc_pkg::FG_RST;
      green_o <= epc_pkg::FG_RST;
      blue_o  <= epc_pkg::FG_RST;
    end
    else
    begin
      red_o   <= red_nxt;
      green_o <= green_nxt;
      blue_o  <= blue_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- hw/epc_regs.sv ----
// Wishbone register bank for shape parameters and foreground colour
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module epc_regs
#(
  parameter int ADR_W = 10
)
(
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Wishbone classic slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [ADR_W-1:0]             wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // Drawing engine handshake
  input  wire logic                         draw_done_i,
  output logic                              draw_start_o,
  output logic                              draw_stop_o,
  output logic                              draw_busy_o,
  // Shape selection
  output logic      [1:0]                   shape_sel_o,
  output logic                              fill_o,
  output logic      [1:0]                   arc_part_o,
  // Geometry in pixels
  output logic      [epc_pkg::COORD_W-1:0]  major_radius_o,
  output logic      [epc_pkg::COORD_W-1:0]  minor_radius_o,
  output logic      [epc_pkg::COORD_W-1:0]  centre_x_o,
  output logic      [epc_pkg::COORD_W-1:0]  centre_y_o,
  // Foreground colour components
  output logic      [7:0]                   fg_red_o,
  output logic      [7:0]                   fg_green_o,
  output logic      [7:0]                   fg_blue_o
);

  function automatic logic [7:0] hi_byte(input logic [epc_pkg::COORD_W-1:0] v);
    hi_byte = {3'h0, v[12:8]};
  endfunction

  logic [epc_pkg::IDX_W-1:0]    idx;
  logic                         access;
  logic                         wr;
  logic [7:0]                   wbyte;
  logic [epc_pkg::COORD_W-1:0]  major_v;
  logic [epc_pkg::COORD_W-1:0]  minor_v;
  logic [epc_pkg::COORD_W-1:0]  cx_v;
  logic [epc_pkg::COORD_W-1:0]  cy_v;
  logic [7:0]                   fg_red_r;
  logic [7:0]                   fg_green_r;
  logic [7:0]                   fg_blue_r;
  logic [1:0]                   mode_r;
  logic                         busy_r;
  logic                         fill_r;
  logic [1:0]                   shape_r;
  logic [1:0]                   part_r;
  logic [31:0]                  rdata_nxt;

  // One access per request; ack is answered one cycle after stb rises
  assign idx    = wb_adr_i[ADR_W-1:2];
  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr     = access & wb_we_i & wb_sel_i[0];
  assign wbyte  = wb_dat_i[7:0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= access;
    end
  end

  // Geometry byte pairs
  epc_coord_reg u_major
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_lo_i (wr && idx == epc_pkg::IDX_MAJOR_LO),
    .wr_hi_i (wr && idx == epc_pkg::IDX_MAJOR_HI),
    .wdata_i (wbyte),
    .value_o (major_v)
  );

  epc_coord_reg u_minor
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_lo_i (wr && idx == epc_pkg::IDX_MINOR_LO),
    .wr_hi_i (wr && idx == epc_pkg::IDX_MINOR_HI),
    .wdata_i (wbyte),
    .value_o (minor_v)
  );

  epc_coord_reg u_cx
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_lo_i (wr && idx == epc_pkg::IDX_CENTRE_X_LO),
    .wr_hi_i (wr && idx == epc_pkg::IDX_CENTRE_X_HI),
    .wdata_i (wbyte),
    .value_o (cx_v)
  );

  epc_coord_reg u_cy
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_lo_i (wr && idx == epc_pkg::IDX_CENTRE_Y_LO),
    .wr_hi_i (wr && idx == epc_pkg::IDX_CENTRE_Y_HI),
    .wdata_i (wbyte),
    .value_o (cy_v)
  );

  // Geometry is passed on unscaled, one count per pixel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      major_radius_o <= epc_pkg::COORD_RST;
      minor_radius_o <= epc_pkg::COORD_RST;
      centre_x_o     <= epc_pkg::COORD_RST;
      centre_y_o     <= epc_pkg::COORD_RST;
    end
    else
    begin
      major_radius_o <= major_v;
      minor_radius_o <= minor_v;
      centre_x_o     <= cx_v;
      centre_y_o     <= cy_v;
    end
  end

  // Foreground colour bytes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fg_red_r   <= epc_pkg::FG_RST;
      fg_green_r <= epc_pkg::FG_RST;
      fg_blue_r  <= epc_pkg::FG_RST;
    end
    else if (wr)
    begin
      if (idx == epc_pkg::IDX_FG_RED)
      begin
        fg_red_r <= wbyte;
      end
      else if (idx == epc_pkg::IDX_FG_GREEN)
      begin
        fg_green_r <= wbyte;
      end
      else if (idx == epc_pkg::IDX_FG_BLUE)
      begin
        fg_blue_r <= wbyte;
      end
    end
  end

  // Colour depth select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= epc_pkg::MODE_RST;
    end
    else if (wr && idx == epc_pkg::IDX_COLOUR_MODE)
    begin
      mode_r <= wbyte[1:0];
    end
  end

  epc_fg_fmt u_fmt
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .mode_i  (mode_r),
    .red_i   (fg_red_r),
    .green_i (fg_green_r),
    .blue_i  (fg_blue_r),
    .red_o   (fg_red_o),
    .green_o (fg_green_o),
    .blue_o  (fg_blue_o)
  );

  // Shape control fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fill_r  <= 1'b0;
      shape_r <= epc_pkg::FIELD2_RST;
      part_r  <= epc_pkg::FIELD2_RST;
    end
    else if (wr && idx == epc_pkg::IDX_SHAPE_CTRL)
    begin
      fill_r  <= wbyte[epc_pkg::SC_FILL_BIT];
      shape_r <= wbyte[epc_pkg::SC_SHAPE_LSB +: 2];
      part_r  <= wbyte[epc_pkg::SC_PART_LSB +: 2];
    end
  end

  // Run bit: a start in the same cycle as engine completion keeps busy set
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_r <= 1'b0;
    end
    else if (wr && idx == epc_pkg::IDX_SHAPE_CTRL)
    begin
      busy_r <= wbyte[epc_pkg::SC_RUN_BIT];
    end
    else if (draw_done_i)
    begin
      busy_r <= 1'b0;
    end
  end

  // One-cycle start and stop pulses towards the engine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      draw_start_o <= 1'b0;
      draw_stop_o  <= 1'b0;
    end
    else
    begin
      draw_start_o <= wr && idx == epc_pkg::IDX_SHAPE_CTRL && wbyte[epc_pkg::SC_RUN_BIT];
      draw_stop_o  <= wr && idx == epc_pkg::IDX_SHAPE_CTRL && !wbyte[epc_pkg::SC_RUN_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shape_sel_o <= epc_pkg::FIELD2_RST;
      fill_o      <= 1'b0;
      arc_part_o  <= epc_pkg::FIELD2_RST;
      draw_busy_o <= 1'b0;
    end
    else
    begin
      shape_sel_o <= shape_r;
      fill_o      <= fill_r;
      arc_part_o  <= part_r;
      draw_busy_o <= busy_r;
    end
  end

  // Read decode; unmapped indices read as zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (idx == epc_pkg::IDX_SHAPE_CTRL)
    begin
      rdata_nxt[7:0] = {busy_r, fill_r, shape_r, 2'h0, part_r};
    end
    else if (idx == epc_pkg::IDX_MAJOR_LO)
    begin
      rdata_nxt[7:0] = major_v[7:0];
    end
    else if (idx == epc_pkg::IDX_MAJOR_HI)
    begin
      rdata_nxt[7:0] = hi_byte(major_v);
    end
    else if (idx == epc_pkg::IDX_MINOR_LO)
    begin
      rdata_nxt[7:0] = minor_v[7:0];
    end
    else if (idx == epc_pkg::IDX_MINOR_HI)
    begin
      rdata_nxt[7:0] = hi_byte(minor_v);
    end
    else if (idx == epc_pkg::IDX_CENTRE_X_LO)
    begin
      rdata_nxt[7:0] = cx_v[7:0];
    end
    else if (idx == epc_pkg::IDX_CENTRE_X_HI)
    begin
      rdata_nxt[7:0] = hi_byte(cx_v);
    end
    else if (idx == epc_pkg::IDX_CENTRE_Y_LO)
    begin
      rdata_nxt[7:0] = cy_v[7:0];
    end
    else if (idx == epc_pkg::IDX_CENTRE_Y_HI)
    begin
      rdata_nxt[7:0] = hi_byte(cy_v);
    end
    else if (idx == epc_pkg::IDX_COLOUR_MODE)
    begin
      rdata_nxt[1:0] = mode_r;
    end
    else if (idx == epc_pkg::IDX_FG_RED)
    begin
      rdata_nxt[7:0] = fg_red_r;
    end
    else if (idx == epc_pkg::IDX_FG_GREEN)
    begin
      rdata_nxt[7:0] = fg_green_r;
    end
    else if (idx == epc_pkg::IDX_FG_BLUE)
    begin
      rdata_nxt[7:0] = fg_blue_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (access && !wb_we_i)
    begin
      wb_dat_o <= rdata_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- sim/epc_regs_chk.sv ----
// Port assertions for the shape parameter register bank
`timescale 1ns/1ps
`default_nettype none
module epc_regs_chk
#(
  parameter int ADR_W = 10
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [31:0]       wb_dat_o,
  input  wire logic              wb_ack_o,
  input  wire logic              draw_start_o,
  input  wire logic              draw_stop_o,
  input  wire logic              draw_busy_o,
  input  wire logic [1:0]        shape_sel_o,
  input  wire logic [12:0]       major_radius_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A byte write taken by the slave at this edge
  sequence wr_s(logic [7:0] idx);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i[ADR_W-1:2] == idx;
  endsequence

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  start_pulse_a: assert property (wr_s(epc_pkg::IDX_SHAPE_CTRL) ##0 wb_dat_i[7]
    |=> draw_start_o && !draw_stop_o ##1 !draw_start_o && draw_busy_o)
    else $error("start write gave wrong start or busy");
  stop_pulse_a: assert property (wr_s(epc_pkg::IDX_SHAPE_CTRL) ##0 !wb_dat_i[7]
    |=> draw_stop_o && !draw_start_o ##1 !draw_busy_o)
    else $error("stop write gave wrong stop or busy");
  // Field registers change at the taken edge, the output stage one edge later
  shape_sel_a: assert property (wr_s(epc_pkg::IDX_SHAPE_CTRL)
    |=> ##1 shape_sel_o == $past(wb_dat_i[5:4], 2))
    else $error("shape select not taken");
  major_low_a: assert property (wr_s(epc_pkg::IDX_MAJOR_LO)
    |=> ##1 major_radius_o[7:0] == $past(wb_dat_i[7:0], 2))
    else $error("major radius low byte wrong");
  major_high_a: assert property (wr_s(epc_pkg::IDX_MAJOR_HI)
    |=> ##1 major_radius_o[12:8] == $past(wb_dat_i[4:0], 2))
    else $error("major radius high bits wrong");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule

bind epc_regs epc_regs_chk #(.ADR_W(ADR_W)) epc_regs_chk_inst (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .draw_start_o, .draw_stop_o, .draw_busy_o, .shape_sel_o, .major_radius_o);
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the shape parameter register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, draw_done_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, draw_start_o, draw_stop_o, draw_busy_o, fill_o;
  logic [1:0]  shape_sel_o, arc_part_o;
  logic [12:0] major_radius_o, minor_radius_o, centre_x_o, centre_y_o;
  logic [7:0]  fg_red_o, fg_green_o, fg_blue_o, lo, hi, r, g, b, er, eg, eb, f, d;
  logic [51:0] geo;
  logic [31:0] exp_q[$];
  int          fails, samples_checked, seed, cycles, i;

  assign geo = {centre_y_o, centre_x_o, minor_radius_o, major_radius_o};

  epc_regs #(.ADR_W(10)) epc_regs_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .draw_done_i, .draw_start_o,
    .draw_stop_o, .draw_busy_o, .shape_sel_o, .fill_o, .arc_part_o, .major_radius_o,
    .minor_radius_o, .centre_x_o, .centre_y_o, .fg_red_o, .fg_green_o, .fg_blue_o);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One classic cycle, released at the edge that sees ack
  task automatic xfer(input logic [7:0] idx, input logic we, input logic [7:0] v);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, v};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    xfer(idx, 1'b0, 8'h00);
  endtask

  task automatic end_of_test;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read data is compared against the oldest note
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      chk("read data", exp_q.pop_front(), wb_dat_o);

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, draw_done_i} = 5'h10;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    seed = 69;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("fg reset", 32'h070703, {8'h0, fg_red_o, fg_green_o, fg_blue_o});
    for (i = 0; i < 8; i++)
      rd(8'(8'h77 + i), 8'h00);
    for (i = 0; i < 3; i++)
      rd(8'(8'hd2 + i), 8'hff);
    for (i = 0; i < 4; i++)
    begin
      lo = 8'($random(seed));
      hi = 8'($random(seed)) | 8'he0;
      xfer(8'(8'h77 + 2 * i), 1'b1, lo);
      xfer(8'(8'h78 + 2 * i), 1'b1, hi);
      rd(8'(8'h77 + 2 * i), lo);
      rd(8'(8'h78 + 2 * i), {3'h0, hi[4:0]});
      chk("geometry", {19'h0, hi[4:0], lo}, {19'h0, geo[13 * i +: 13]});
    end
    xfer(8'h79, 1'b1, major_radius_o[7:0]);
    xfer(8'h7a, 1'b1, {3'h0, major_radius_o[12:8]});
    for (i = 0; i < 4; i++)
    begin
      xfer(8'h10, 1'b1, 8'(i));
      r = 8'($random(seed));
      g = 8'($random(seed));
      b = 8'($random(seed));
      xfer(8'hd2, 1'b1, r);
      xfer(8'hd3, 1'b1, g);
      xfer(8'hd4, 1'b1, b);
      @(posedge clk_i);
      case (i)
        0: {er, eg, eb} = {5'h0, r[7:5], 5'h0, g[7:5], 6'h0, b[7:6]};
        1: {er, eg, eb} = {3'h0, r[7:3], 2'h0, g[7:2], 3'h0, b[7:3]};
        default: {er, eg, eb} = {r, g, b};
      endcase
      chk("fg red", {24'h0, er}, {24'h0, fg_red_o});
      chk("fg green", {24'h0, eg}, {24'h0, fg_green_o});
      chk("fg blue", {24'h0, eb}, {24'h0, fg_blue_o});
      rd(8'hd4, b);
    end
    for (i = 0; i < 4; i++)
    begin
      f = 8'($random(seed));
      d = {1'b1, f[0], i[1:0], 2'b11, f[2:1]};
      xfer(8'h76, 1'b1, d);
      @(posedge clk_i);
      chk("shape", {27'h0, i[1:0], f[0], f[2:1]}, {27'h0, shape_sel_o, fill_o, arc_part_o});
      chk("busy set", 32'h1, {31'h0, draw_busy_o});
      rd(8'h76, d & 8'hf3);
      if (i == 3)
        xfer(8'h76, 1'b1, d & 8'h73);
      else
      begin
        draw_done_i <= 1'b1;
        @(posedge clk_i);
        draw_done_i <= 1'b0;
      end
      rd(8'h76, d & 8'h73);
      chk("busy clear", 32'h0, {31'h0, draw_busy_o});
    end
    xfer(8'h20, 1'b1, 8'h5a);
    rd(8'h20, 8'h00);
    repeat (3) @(posedge clk_i);
    end_of_test();
  end
endmodule
`default_nettype wire
